//--- common/acs_pkg.sv
// Constants and types for the conversion sequencer
package acs_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ACS_OFS_CONTROL = 8'h00;
	localparam logic [7:0] ACS_OFS_CONFIG = 8'h01;
	localparam logic [7:0] ACS_OFS_STATUS = 8'h02;
	localparam logic [7:0] ACS_CONTROL_RESET = 8'h00;
	localparam logic [7:0] ACS_CONFIG_RESET = 8'h00;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ACS_CTL_ENABLE = 0;
	localparam int ACS_CTL_FLUSH = 1;
	localparam int ACS_CTL_START = 2;
	localparam int ACS_CFG_RES_LO = 1;
	localparam int ACS_CFG_CONTINUOUS_CONVERT = 3;
	localparam int ACS_CFG_SIGNED = 4;
	localparam int ACS_CFG_CAP_LO = 5;
	localparam int ACS_STA_BUSY = 0;
	localparam int ACS_STA_CLK = 1;
	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [2:0] ACS_ACT_START = 3'h1;
	localparam logic [2:0] ACS_ACT_FLUSH = 3'h6;
	localparam logic [1:0] ACS_RES_12R = 2'h0;
	localparam logic [1:0] ACS_RES_12X = 2'h1;
	localparam logic [1:0] ACS_RES_8R = 2'h2;
	localparam logic [1:0] ACS_RES_12L = 2'h3;
	localparam logic [6:0] ACS_BITS_8 = 7'h08;
	localparam logic [6:0] ACS_BITS_12 = 7'h0c;
	// Gain delay in half converter clocks
	localparam logic [6:0] ACS_GH_UNITY = 7'h00;
	localparam logic [6:0] ACS_GH_LOW = 7'h02;
	localparam logic [6:0] ACS_GH_MID = 7'h04;
	localparam logic [6:0] ACS_GH_HIGH = 7'h06;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int ACS_CLK_HZ = 100_000_000;
	localparam int ACS_LOW_SPS = 225_000;
	localparam int ACS_MED_SPS = 150_000;
	localparam int ACS_HIGH_SPS = 75_000;
	localparam logic [15:0] ACS_GAP_LOW = 16'((ACS_CLK_HZ + ACS_LOW_SPS - 1) / ACS_LOW_SPS);
	localparam logic [15:0] ACS_GAP_MED = 16'((ACS_CLK_HZ + ACS_MED_SPS - 1) / ACS_MED_SPS);
	localparam logic [15:0] ACS_GAP_HIGH = 16'((ACS_CLK_HZ + ACS_HIGH_SPS - 1) / ACS_HIGH_SPS);
	typedef enum logic [1:0] {ACS_IDLE = 2'b00, ACS_CONV = 2'b01} acs_state_t;
endpackage

//--- hw/acs_sequencer.sv
// Conversion clock divider, timing sequencer and control registers
// Behaviour
// - Divide peripheral clock; sequence on divided clock
// - Conversion length: half(resolution+sample)+gain
// - Gain term 0, 1, 2 or 3 cycles
// - Result latency equals one conversion period
// - Msb first, then one bit per half
// - Result ready when completion flag rises
// - Start must precede converter edge by one
// - Input sampled in first half cycle
// - Each gain doubling adds one cycle
// - Each result raises a memory mover request
// - Interrupt and event on done; with compare on, only on a compare hit
// - Flush aborts, resets divider, starts next cycle
// - Pending starts launch right after flush unless the supply cap gap is unmet
// - Start bit launches, hardware clears it
// - Flush bit aborts, restarts converter clock
// - After flush sequencing resumes pending work
// - Enable bit gates all conversions
// - Supply cap field limits sample rate
// - Config bit 4 selects signed results
// - Continuous mode restarts after each conversion
// - Bits 2:1 pick resolution and justification
// - Resolution codes map to result layouts
// - Prescaler divides by 4 up to 512
// - Trigger action 110 flushes and restarts
module acs_sequencer #(
	parameter int SAMP_W = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// Settings held elsewhere
	input wire logic [2:0] prescale_code,
	input wire logic [SAMP_W-1:0] sample_window_length,
	input wire logic [1:0] amplification_delay_term,
	input wire logic [2:0] trigger_action_select,
	input wire logic direct_memory_mover,
	input wire logic cmp_enable,
	input wire logic cmp_above,
	input wire logic [11:0] cmp_value,
	// Event and analog side
	input wire logic trig_event,
	input wire logic [11:0] adc_data,
	output logic sample_hold,
	output logic adc_clk,
	// Results and requests
	output logic [15:0] result,
	output logic conv_done,
	output logic int_request,
	output logic event_out,
	output logic dma_req,
	output logic busy
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	acs_pkg::acs_state_t state;
	logic en;
	logic [1:0] res;
	logic continuous_convert;
	logic signd;
	logic [1:0] cap;
	logic start_pend;
	logic [8:0] dcnt;
	logic [6:0] hcnt;
	logic [6:0] len_q;
	logic [6:0] rbits_q;
	logic [15:0] pcnt;
	logic [11:0] sample_q;
	logic [11:0] sar;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [6:0] gain_halves(input logic [1:0] code);
		// Unity 0, low 1 cycle, mid 2 halves more, high 3 cycles
		unique case (code)
			2'h0: gain_halves = acs_pkg::ACS_GH_UNITY;
			2'h1: gain_halves = acs_pkg::ACS_GH_LOW;
			2'h2: gain_halves = acs_pkg::ACS_GH_MID;
			2'h3: gain_halves = acs_pkg::ACS_GH_HIGH;
		endcase
	endfunction

	function automatic logic [15:0] fmt(input logic [11:0] v, input logic [1:0] r,
			input logic s);
		unique case (r)
			acs_pkg::ACS_RES_8R: fmt = {{8{s & v[11]}}, v[11:4]};
			acs_pkg::ACS_RES_12L: fmt = {v, 4'h0};
			acs_pkg::ACS_RES_12R, acs_pkg::ACS_RES_12X: fmt = {{4{s & v[11]}}, v};
		endcase
	endfunction

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	wire wr_ctl = wr & (addr == acs_pkg::ACS_OFS_CONTROL);
	wire wr_cfg = wr & (addr == acs_pkg::ACS_OFS_CONFIG);
	wire [7:0] ctl_view = {5'h00, start_pend, 1'b0, en};
	wire [7:0] cfg_view = {1'b0, cap, signd, continuous_convert, res, 1'b0};
	wire [7:0] sta_view = {6'h00, adc_clk, busy};
	wire [7:0] next_rdata = !rd ? 8'h00 :
		(addr == acs_pkg::ACS_OFS_CONTROL) ? ctl_view :
		(addr == acs_pkg::ACS_OFS_CONFIG) ? cfg_view :
		(addr == acs_pkg::ACS_OFS_STATUS) ? sta_view : 8'h00;

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	// Half period is half the division factor: 2 << code
	wire [8:0] half = 9'h002 << prescale_code;
	wire tick = en & (dcnt == half - 9'h001);
	wire tick_rise = tick & ~adc_clk;

	// ----------------------------------------
	// Triggers and start control
	// ----------------------------------------
	wire ev_start = trig_event & (trigger_action_select == acs_pkg::ACS_ACT_START);
	wire ev_flush = trig_event & (trigger_action_select == acs_pkg::ACS_ACT_FLUSH);
	wire flush_go = en & ((wr_ctl & wdata[acs_pkg::ACS_CTL_FLUSH]) | ev_flush);
	wire [15:0] min_gap = (cap == 2'h1) ? acs_pkg::ACS_GAP_LOW :
		(cap == 2'h2) ? acs_pkg::ACS_GAP_MED :
		(cap == 2'h3) ? acs_pkg::ACS_GAP_HIGH : 16'h0000;
	// One bit wider so a saturated count cannot wrap to zero
	wire [16:0] gap_seen = {1'b0, pcnt} + 17'h00001;
	wire gap_ok = gap_seen >= {1'b0, min_gap};
	wire idle = (state == acs_pkg::ACS_IDLE);
	// Start sampled from a flop, so it leads the edge by a cycle
	wire start_take = tick_rise & start_pend & gap_ok & idle & ~flush_go;
	wire fin = en & ~flush_go & ~idle & tick & (hcnt == len_q - 7'h01);
	wire start_set = (wr_ctl & wdata[acs_pkg::ACS_CTL_START]) | ev_start | ev_flush |
		(fin & continuous_convert);
	// A fresh request wins over the clear from a launch
	wire next_pend = start_set | (start_pend & ~start_take);

	// ----------------------------------------
	// Conversion length and bit resolution
	// ----------------------------------------
	wire [6:0] rbits = (res == acs_pkg::ACS_RES_8R) ? acs_pkg::ACS_BITS_8 :
		acs_pkg::ACS_BITS_12;
	wire [6:0] len = rbits + 7'(sample_window_length) +
		gain_halves(amplification_delay_term);
	wire [6:0] rstart = len_q - rbits_q;
	wire in_res = ~idle & tick & (hcnt >= rstart);
	wire [6:0] bidx = hcnt - rstart;
	wire [3:0] bpos = 4'(7'd11 - bidx);
	// Msb tick can coincide with the capture, so read the live word then
	wire [11:0] cur_sample = sample_hold ? adc_data : sample_q;
	logic [11:0] next_sar;
	always_comb begin
		next_sar = sar;
		if (in_res) begin
			next_sar[bpos] = cur_sample[bpos];
		end
	end
	wire hit = cmp_above ? (next_sar > cmp_value) : (next_sar < cmp_value);
	wire raise = fin & (~cmp_enable | hit);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en <= acs_pkg::ACS_CONTROL_RESET[acs_pkg::ACS_CTL_ENABLE];
			{cap, signd, continuous_convert, res} <= acs_pkg::ACS_CONFIG_RESET[6:1];
			rdata <= 8'h00;
		end else begin
			if (wr_ctl) begin
				en <= wdata[acs_pkg::ACS_CTL_ENABLE];
			end
			if (wr_cfg) begin
				{cap, signd, continuous_convert, res} <= wdata[6:1];
			end
			rdata <= next_rdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dcnt <= 9'h000;
			adc_clk <= 1'b0;
		end else if (flush_go) begin
			// Loaded so the very next cycle is a rising edge
			dcnt <= half - 9'h001;
			adc_clk <= 1'b0;
		end else if (!en) begin
			dcnt <= 9'h000;
			adc_clk <= 1'b0;
		end else if (tick) begin
			dcnt <= 9'h000;
			adc_clk <= ~adc_clk;
		end else begin
			dcnt <= dcnt + 9'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_pend <= 1'b0;
			pcnt <= 16'hffff;
		end else begin
			start_pend <= next_pend;
			if (start_take) begin
				pcnt <= 16'h0000;
			end else if (pcnt != 16'hffff) begin
				pcnt <= pcnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= acs_pkg::ACS_IDLE;
			hcnt <= 7'h00;
			len_q <= 7'h00;
			rbits_q <= 7'h00;
		end else if (!en || flush_go) begin
			// In-flight work is dropped; the pending start stays
			state <= acs_pkg::ACS_IDLE;
			hcnt <= 7'h00;
		end else begin
			unique case (state)
				acs_pkg::ACS_IDLE: begin
					if (start_take) begin
						state <= acs_pkg::ACS_CONV;
						hcnt <= 7'h00;
						len_q <= len;
						rbits_q <= rbits;
					end
				end
				acs_pkg::ACS_CONV: begin
					if (fin) begin
						state <= acs_pkg::ACS_IDLE;
					end else if (tick) begin
						hcnt <= hcnt + 7'h01;
					end
				end
				default: begin
					state <= acs_pkg::ACS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_hold <= 1'b0;
			sample_q <= 12'h000;
			sar <= 12'h000;
		end else if (start_take) begin
			sample_hold <= 1'b1;
			sar <= 12'h000;
		end else begin
			if (sample_hold && (tick || flush_go || !en)) begin
				sample_hold <= 1'b0;
				sample_q <= adc_data;
			end
			sar <= next_sar;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			result <= 16'h0000;
			conv_done <= 1'b0;
			int_request <= 1'b0;
			event_out <= 1'b0;
			dma_req <= 1'b0;
			busy <= 1'b0;
		end else begin
			if (fin) begin
				result <= fmt(next_sar, res, signd);
			end
			conv_done <= fin;
			int_request <= raise;
			event_out <= raise;
			dma_req <= fin & direct_memory_mover;
			busy <= (~idle & ~fin & en & ~flush_go) | start_take;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Cycles since launch, to tie the period to the divider
	logic [16:0] pc;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pc <= 17'h00000;
		end else if (start_take) begin
			pc <= 17'h00001;
		end else begin
			pc <= pc + 17'h00001;
		end
	end

	property p_len;
		@(posedge clk) disable iff (!rst_b)
		conv_done && $stable(prescale_code) |->
			pc == (17'(len_q) * 17'(half)) + 17'h00001;
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");

	property p_launch;
		@(posedge clk) disable iff (!rst_b)
		$rose(busy) |-> $past(tick_rise) && $past(start_pend);
	endproperty
	a_launch: assert property (p_launch) else $error("launch off edge");

	property p_sample;
		@(posedge clk) disable iff (!rst_b)
		$rose(busy) |-> sample_hold && adc_clk;
	endproperty
	a_sample: assert property (p_sample) else $error("no sampling at start");

	property p_flush_edge;
		@(posedge clk) disable iff (!rst_b)
		flush_go |=> tick_rise && !busy;
	endproperty
	a_flush_edge: assert property (p_flush_edge) else $error("flush restart bad");

	property p_flush_resume;
		@(posedge clk) disable iff (!rst_b)
		flush_go && start_pend && cap == 2'h0 && !wr |-> ##2 busy;
	endproperty
	a_flush_resume: assert property (p_flush_resume) else $error("pending lost");

	property p_disable;
		@(posedge clk) disable iff (!rst_b)
		!en |=> !busy && !conv_done;
	endproperty
	a_disable: assert property (p_disable) else $error("runs while off");

	property p_dma;
		@(posedge clk) disable iff (!rst_b)
		conv_done |-> dma_req == $past(direct_memory_mover);
	endproperty
	a_dma: assert property (p_dma) else $error("mover request wrong");

	property p_continuous_convert;
		@(posedge clk) disable iff (!rst_b)
		conv_done && $past(continuous_convert) |-> start_pend;
	endproperty
	a_continuous_convert: assert property (p_continuous_convert) else $error("no restart");

	property p_res8;
		@(posedge clk) disable iff (!rst_b)
		conv_done && $past(res) == acs_pkg::ACS_RES_8R && !$past(signd) |->
			result[15:8] == 8'h00;
	endproperty
	a_res8: assert property (p_res8) else $error("8-bit layout wrong");

	property p_start_clear;
		@(posedge clk) disable iff (!rst_b)
		start_take && !start_set |=> !start_pend;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start not cleared");

	property p_hold_half;
		@(posedge clk) disable iff (!rst_b)
		sample_hold && tick |=> !sample_hold;
	endproperty
	a_hold_half: assert property (p_hold_half) else $error("sampling past first half");

	property p_pend_keep;
		@(posedge clk) disable iff (!rst_b)
		start_pend && !idle |=> start_pend;
	endproperty
	a_pend_keep: assert property (p_pend_keep) else $error("pending start lost");
endmodule

//--- tb/acs_front_model.sv
// Analog input and event trigger model for the sequencer bench
module acs_front_model (
	// Clock
	input wire logic clk,
	// Converter side
	input wire logic sample_hold,
	output logic [11:0] adc_data,
	output logic trig_event
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] level = 12'habc;
	initial trig_event = 1'b0;
	// Input is only valid while held, so show the inverse outside that window
	assign adc_data = sample_hold ? level : ~level;
	// One-cycle pulse, raised at least a cycle before the converter edge that uses it
	task automatic fire;
		@(posedge clk);
		trig_event <= 1'b1;
		@(posedge clk);
		trig_event <= 1'b0;
	endtask
endmodule

//--- tb/tb_acs_sequencer.sv
// Self-checking bench for the conversion sequencer
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_acs_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, direct_memory_mover = 1'b0;
	logic cmp_enable = 1'b0, cmp_above = 1'b0, a0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
	logic [2:0] prescale_code = 3'h0, trigger_action_select = 3'h0;
	logic [5:0] sample_window_length = 6'h00;
	logic [1:0] amplification_delay_term = 2'h0;
	logic [11:0] cmp_value = 12'h000, adc_data;
	logic sample_hold, adc_clk, conv_done, int_request, event_out, dma_req, busy, trig_event;
	logic [15:0] result;
	logic [15:0] ex [2][4] = '{'{16'h0abc, 16'h0abc, 16'h00ab, 16'habc0},
		'{16'hfabc, 16'hfabc, 16'hffab, 16'habc0}};
	int gh[4] = '{0, 2, 4, 6};
	// Ceiling of clock over capped rate; first entry is the uncapped conversion length (12 halves of 2 cycles)
	int gap[4] = '{24, 445, 667, 1334};
	int checks = 0, n_mismatch = 0, cyc = 0, k, m, t0;
	always #5 clk = ~clk;
	acs_front_model fe (.clk(clk), .sample_hold(sample_hold), .adc_data(adc_data),
		.trig_event(trig_event));
	acs_sequencer #(.SAMP_W(6)) uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .prescale_code(prescale_code),
		.sample_window_length(sample_window_length),
		.amplification_delay_term(amplification_delay_term),
		.trigger_action_select(trigger_action_select),
		.direct_memory_mover(direct_memory_mover), .cmp_enable(cmp_enable),
		.cmp_above(cmp_above), .cmp_value(cmp_value), .trig_event(trig_event),
		.adc_data(adc_data), .sample_hold(sample_hold), .adc_clk(adc_clk), .result(result),
		.conv_done(conv_done), .int_request(int_request), .event_out(event_out),
		.dma_req(dma_req), .busy(busy));
	// ----------------------------------------
	// Bus and sequence helpers
	// ----------------------------------------
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK("rdata", e, rdata)
	endtask
	task automatic wdone(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (conv_done !== 1'b1 && n < 3000);
		`CHK("done_seen", 1'b1, conv_done)
	endtask
	// Zero control byte means start from the trigger line instead
	task automatic conv(input logic [7:0] cfg, v, input int len, h,
		input logic [15:0] er, input logic ei);
		int n, j, q;
		n = 0;
		j = 0;
		q = 0;
		wreg(8'h01, cfg);
		if (v != 8'h00) begin
			wreg(8'h00, v);
		end else begin
			fe.fire();
		end
		// Busy run is counted afresh after any abort
		while (conv_done !== 1'b1 && j < 9000) begin
			@(posedge clk);
			#1;
			j++;
			if (busy !== 1'b1 && conv_done !== 1'b1) begin
				n = 0;
				q = 0;
			end
			n += (busy === 1'b1) ? 1 : 0;
			q += (sample_hold === 1'b1) ? 1 : 0;
		end
		`CHK("busy_len", len * h, n)
		`CHK("hold_len", h, q)
		`CHK("latency", 1'b1, j > len * h && j <= len * h + 2 * h + 4)
		`CHK("result", er, result)
		`CHK("irq", ei, int_request)
		`CHK("event", ei, event_out)
		`CHK("dma", direct_memory_mover, dma_req)
	endtask
	task automatic test_done;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_mismatch++;
			test_done();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rchk(8'h00, 8'h00);
		rchk(8'h01, 8'h00);
		rchk(8'h02, 8'h00);
		rchk(8'h05, 8'h00);
		wreg(8'h01, 8'hff);
		rchk(8'h01, 8'h7e);
		wreg(8'h00, 8'hf8);
		rchk(8'h00, 8'h00);
		wreg(8'h01, 8'h00);
		wreg(8'h00, 8'h04);
		repeat (40) @(posedge clk);
		#1 `CHK("idle", 1'b0, busy)
		rchk(8'h00, 8'h04);
		for (int s = 0; s < 2; s++) begin
			for (int r = 0; r < 4; r++) begin
				direct_memory_mover <= r[0];
				conv(8'((s << 4) | (r << 1)), 8'h05, (r == 2) ? 8 : 12, 2, ex[s][r], 1'b1);
			end
		end
		rchk(8'h00, 8'h01);
		for (int g = 0; g < 4; g++) begin
			amplification_delay_term <= 2'(g);
			sample_window_length <= 6'(g + 3);
			conv(8'h00, 8'h05, 15 + g + gh[g], 2, 16'h0abc, 1'b1);
		end
		sample_window_length <= 6'h00;
		amplification_delay_term <= 2'h0;
		for (int p = 7; p >= 0; p--) begin
			wreg(8'h00, 8'h00);
			prescale_code <= 3'(p);
			wreg(8'h00, 8'h01);
			m = 0;
			a0 = 1'b1;
			for (int i = 0; i < 2000 && m < 3; i++) begin
				@(posedge clk);
				#1;
				if (adc_clk === 1'b1 && a0 === 1'b0) begin
					m++;
					t0 = (m == 2) ? i : t0;
					if (m == 3) `CHK("adc_clk_period", 4 << p, i - t0)
				end
				a0 = adc_clk;
			end
			`CHK("adc_clk_rises", 3, m)
			conv(8'h00, 8'h05, 12, 2 << p, 16'h0abc, 1'b1);
		end
		cmp_enable <= 1'b1;
		cmp_above <= 1'b1;
		cmp_value <= 12'hb00;
		conv(8'h00, 8'h05, 12, 2, 16'h0abc, 1'b0);
		cmp_value <= 12'ha00;
		conv(8'h00, 8'h05, 12, 2, 16'h0abc, 1'b1);
		cmp_above <= 1'b0;
		conv(8'h00, 8'h05, 12, 2, 16'h0abc, 1'b0);
		cmp_enable <= 1'b0;
		trigger_action_select <= 3'h1;
		conv(8'h00, 8'h00, 12, 2, 16'h0abc, 1'b1);
		trigger_action_select <= 3'h6;
		conv(8'h00, 8'h00, 12, 2, 16'h0abc, 1'b1);
		wreg(8'h00, 8'h05);
		repeat (4) @(posedge clk);
		wreg(8'h00, 8'h05);
		rchk(8'h00, 8'h05);
		conv(8'h00, 8'h00, 12, 2, 16'h0abc, 1'b1);
		trigger_action_select <= 3'h0;
		wreg(8'h00, 8'h05);
		repeat (8) @(posedge clk);
		conv(8'h00, 8'h07, 12, 2, 16'h0abc, 1'b1);
		for (int c = 0; c < 4; c++) begin
			wreg(8'h01, 8'(8 | (c << 5)));
			wreg(8'h00, 8'h05);
			wdone(k);
			wdone(k);
			`CHK("spacing", 1'b1, k >= gap[c] && k <= gap[c] + 8)
			wreg(8'h01, 8'h00);
			wdone(k);
		end
		test_done();
	end
endmodule
